// [common/ppu_pkg.sv]
// Package with register map, field positions, reset values and widths of the pulse pattern unit.
package ppu_pkg;
    // Bus and data widths.
    localparam int ADDR_W    = 3;
    localparam int DATA_W    = 8;
    localparam int GRP_W     = 4;
    localparam int NUM_CH    = 4;
    localparam int SEL_W     = 2;

    // Register offsets.
    localparam logic [ADDR_W-1:0] OFS_NEXT_EN      = 3'h0;
    localparam logic [ADDR_W-1:0] OFS_OUT_DATA     = 3'h1;
    localparam logic [ADDR_W-1:0] OFS_NEXT_DATA    = 3'h2;
    localparam logic [ADDR_W-1:0] OFS_NEXT_DATA_G3 = 3'h3;
    localparam logic [ADDR_W-1:0] OFS_NEXT_DATA_G2 = 3'h4;
    localparam logic [ADDR_W-1:0] OFS_TRIG_SEL     = 3'h5;
    localparam logic [ADDR_W-1:0] OFS_OUT_MODE     = 3'h6;

    // Field positions in trigger_select.
    localparam int TSEL_G3_LO = 6;
    localparam int TSEL_G2_LO = 4;

    // Field positions in output_mode.
    localparam int MODE_G3_DIR = 7;
    localparam int MODE_G2_DIR = 6;
    localparam int MODE_G3_NOV = 3;
    localparam int MODE_G2_NOV = 2;

    // Group bit ranges within the 8-bit output word.
    localparam int G3_LO = 4;
    localparam int G2_LO = 0;

    // Fixed read values of reserved bits.
    localparam logic [DATA_W-1:0] TSEL_RSVD_ONES = 8'h0F;
    localparam logic [DATA_W-1:0] MODE_RSVD_ONES = 8'h30;
    localparam logic [DATA_W-1:0] NDR_G3_RSVD    = 8'h0F;
    localparam logic [DATA_W-1:0] NDR_G2_RSVD    = 8'hF0;
    localparam logic [DATA_W-1:0] READ_NONE      = 8'h00;

    // Reset values.
    localparam logic [DATA_W-1:0] NEXT_EN_RST  = 8'h00;
    localparam logic [DATA_W-1:0] OUT_DATA_RST = 8'h00;
    localparam logic [DATA_W-1:0] NEXT_DATA_RST = 8'h00;
    localparam logic [SEL_W-1:0]  TSEL_FLD_RST = 2'h3;
    localparam logic              DIR_RST      = 1'b1;
    localparam logic              NOV_RST      = 1'b0;
endpackage

// [rtl/ppu_trig_sel.sv]
// Trigger selector that picks one timer channel's match A and match B events.
`timescale 1ns/100ps
module ppu_trig_sel (
    // Channel selection.
    input  wire logic [ppu_pkg::SEL_W-1:0]  sel,
    // Timer events, one bit per channel.
    input  wire logic [ppu_pkg::NUM_CH-1:0] match_a,
    input  wire logic [ppu_pkg::NUM_CH-1:0] match_b,
    input  wire logic [ppu_pkg::NUM_CH-1:0] capture_a,
    input  wire logic [ppu_pkg::NUM_CH-1:0] reg_a_is_capture,
    // Selected events.
    output logic                            trig_a,
    output logic                            trig_b
);
    import ppu_pkg::*;

    // A channel whose register A captures drives the A trigger from the capture event.
    always_comb begin
        trig_a = reg_a_is_capture[sel] ? capture_a[sel] : match_a[sel];
        trig_b = match_b[sel];
    end
endmodule // ppu_trig_sel

// [rtl/ppu_group.sv]
// One 4-bit output group: output data register, transfer logic and pin drive.
`timescale 1ns/100ps
module ppu_group (
    // Clock and reset.
    input  wire logic                      clk,
    input  wire logic                      rst_n,
    // Software write of the output data bits.
    input  wire logic                      wr_en,
    input  wire logic [ppu_pkg::GRP_W-1:0] wr_data,
    // Transfer controls.
    input  wire logic [ppu_pkg::GRP_W-1:0] next_data,
    input  wire logic [ppu_pkg::GRP_W-1:0] enable,
    input  wire logic                      trig_a,
    input  wire logic                      trig_b,
    input  wire logic                      nonoverlap,
    input  wire logic                      direct,
    // State and pin drive.
    output logic      [ppu_pkg::GRP_W-1:0] out_data,
    output logic      [ppu_pkg::GRP_W-1:0] pin
);
    import ppu_pkg::*;

    logic [GRP_W-1:0] out_data_r;
    logic [GRP_W-1:0] out_data_nxt;
    logic [GRP_W-1:0] pin_r;

    // Next value of each output data bit from triggers or software.
    always_comb begin
        out_data_nxt = out_data_r;
        for (int i = 0; i < GRP_W; i++) begin
            if (enable[i]) begin
                if (trig_a) begin
                    out_data_nxt[i] = next_data[i];
                end else if (nonoverlap && trig_b && !next_data[i]) begin
                    out_data_nxt[i] = 1'b0;
                end
            end else if (wr_en) begin
                out_data_nxt[i] = wr_data[i];
            end
        end
    end

    // Output data register, updated on the edge that samples the trigger pulse.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            out_data_r <= OUT_DATA_RST[GRP_W-1:0];
        end else begin
            out_data_r <= out_data_nxt;
        end
    end

    // Pin register follows the new data so pins move with the data register.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pin_r <= OUT_DATA_RST[GRP_W-1:0];
        end else begin
            pin_r <= direct ? out_data_nxt : ~out_data_nxt;
        end
    end

    assign out_data = out_data_r;
    assign pin      = pin_r;
endmodule // ppu_group

// [rtl/ppu_top.sv]
// Top of the pulse pattern unit: register file, trigger routing, two output groups and checks.
`timescale 1ns/100ps
module ppu_top (
    // Clock and reset.
    input  wire logic                           CLK,
    input  wire logic                           RST_N,
    // Register port.
    input  wire logic [ppu_pkg::ADDR_W-1:0]     ADDR,
    input  wire logic [ppu_pkg::DATA_W-1:0]     WDATA,
    input  wire logic                           WR,
    input  wire logic                           RD,
    output logic      [ppu_pkg::DATA_W-1:0]     RDATA,
    // Power control: high while the unit is in module stop.
    input  wire logic                           MODULE_STOP,
    // Timer events, one-cycle pulses per channel, and capture configuration level.
    input  wire logic [ppu_pkg::NUM_CH-1:0]     MATCH_A,
    input  wire logic [ppu_pkg::NUM_CH-1:0]     MATCH_B,
    input  wire logic [ppu_pkg::NUM_CH-1:0]     CAPTURE_A,
    input  wire logic [ppu_pkg::NUM_CH-1:0]     REG_A_IS_CAPTURE,
    // Pin sharing: high where another peripheral drives the pin.
    input  wire logic [ppu_pkg::DATA_W-1:0]     OTHER_PERIPH_OE,
    // Pulse output pins, bit 7 is output 15 and bit 0 is output 8.
    output logic      [ppu_pkg::DATA_W-1:0]     PULSE_OUT,
    output logic      [ppu_pkg::DATA_W-1:0]     PULSE_OE
);
    import ppu_pkg::*;

    logic [DATA_W-1:0] next_en_r;
    logic [DATA_W-1:0] next_data_r;
    logic [SEL_W-1:0]  g3_sel_r;
    logic [SEL_W-1:0]  g2_sel_r;
    logic              g3_dir_r;
    logic              g2_dir_r;
    logic              g3_nov_r;
    logic              g2_nov_r;
    logic [DATA_W-1:0] rdata_r;
    logic [DATA_W-1:0] rdata_nxt;
    logic [DATA_W-1:0] out_data;
    logic [DATA_W-1:0] pin;
    logic [DATA_W-1:0] tsel_val;
    logic [DATA_W-1:0] mode_val;
    logic              run;
    logic              wr_ok;
    logic              g3_a;
    logic              g3_b;
    logic              g2_a;
    logic              g2_b;

    // The unit only works and answers while module stop is clear.
    assign run   = !MODULE_STOP;
    assign wr_ok = WR && run;

    // Next data enable register.
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            next_en_r <= NEXT_EN_RST;
        end else if (wr_ok && ADDR == OFS_NEXT_EN) begin
            next_en_r <= WDATA;
        end
    end

    // Next data register, whole or per group.
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            next_data_r <= NEXT_DATA_RST;
        end else if (wr_ok) begin
            case (ADDR)
                OFS_NEXT_DATA: begin
                    next_data_r <= WDATA;
                end
                OFS_NEXT_DATA_G3: begin
                    next_data_r[G3_LO +: GRP_W] <= WDATA[G3_LO +: GRP_W];
                end
                OFS_NEXT_DATA_G2: begin
                    next_data_r[G2_LO +: GRP_W] <= WDATA[G2_LO +: GRP_W];
                end
                default: begin
                    next_data_r <= next_data_r;
                end
            endcase
        end
    end

    // Trigger select fields; reserved bits are not stored.
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            g3_sel_r <= TSEL_FLD_RST;
            g2_sel_r <= TSEL_FLD_RST;
        end else if (wr_ok && ADDR == OFS_TRIG_SEL) begin
            g3_sel_r <= WDATA[TSEL_G3_LO +: SEL_W];
            g2_sel_r <= WDATA[TSEL_G2_LO +: SEL_W];
        end
    end

    // Output mode fields; reserved bits are not stored.
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            g3_dir_r <= DIR_RST;
            g2_dir_r <= DIR_RST;
            g3_nov_r <= NOV_RST;
            g2_nov_r <= NOV_RST;
        end else if (wr_ok && ADDR == OFS_OUT_MODE) begin
            g3_dir_r <= WDATA[MODE_G3_DIR];
            g2_dir_r <= WDATA[MODE_G2_DIR];
            g3_nov_r <= WDATA[MODE_G3_NOV];
            g2_nov_r <= WDATA[MODE_G2_NOV];
        end
    end

    // Read values with reserved bits forced to their fixed levels.
    always_comb begin
        tsel_val = TSEL_RSVD_ONES;
        tsel_val[TSEL_G3_LO +: SEL_W] = g3_sel_r;
        tsel_val[TSEL_G2_LO +: SEL_W] = g2_sel_r;
        mode_val = MODE_RSVD_ONES;
        mode_val[MODE_G3_DIR] = g3_dir_r;
        mode_val[MODE_G2_DIR] = g2_dir_r;
        mode_val[MODE_G3_NOV] = g3_nov_r;
        mode_val[MODE_G2_NOV] = g2_nov_r;
    end

    // Read multiplexer; unmapped or stopped reads return zero.
    always_comb begin
        rdata_nxt = READ_NONE;
        if (RD && run) begin
            case (ADDR)
                OFS_NEXT_EN:      rdata_nxt = next_en_r;
                OFS_OUT_DATA:     rdata_nxt = out_data;
                OFS_NEXT_DATA:    rdata_nxt = next_data_r;
                OFS_NEXT_DATA_G3: rdata_nxt = next_data_r | NDR_G3_RSVD;
                OFS_NEXT_DATA_G2: rdata_nxt = next_data_r | NDR_G2_RSVD;
                OFS_TRIG_SEL:     rdata_nxt = tsel_val;
                OFS_OUT_MODE:     rdata_nxt = mode_val;
                default:          rdata_nxt = READ_NONE;
            endcase
        end
    end

    // Read data stand only in the cycle after the strobe.
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            rdata_r <= READ_NONE;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    assign RDATA = rdata_r;

    // Trigger routing for group 3.
    ppu_trig_sel u_sel_g3 (
        .sel              (g3_sel_r),
        .match_a          (MATCH_A & {NUM_CH{run}}),
        .match_b          (MATCH_B & {NUM_CH{run}}),
        .capture_a        (CAPTURE_A & {NUM_CH{run}}),
        .reg_a_is_capture (REG_A_IS_CAPTURE),
        .trig_a           (g3_a),
        .trig_b           (g3_b)
    );

    // Trigger routing for group 2.
    ppu_trig_sel u_sel_g2 (
        .sel              (g2_sel_r),
        .match_a          (MATCH_A & {NUM_CH{run}}),
        .match_b          (MATCH_B & {NUM_CH{run}}),
        .capture_a        (CAPTURE_A & {NUM_CH{run}}),
        .reg_a_is_capture (REG_A_IS_CAPTURE),
        .trig_a           (g2_a),
        .trig_b           (g2_b)
    );

    // Group 3 drives outputs 15 to 12.
    ppu_group u_grp3 (
        .clk        (CLK),
        .rst_n      (RST_N),
        .wr_en      (wr_ok && ADDR == OFS_OUT_DATA),
        .wr_data    (WDATA[G3_LO +: GRP_W]),
        .next_data  (next_data_r[G3_LO +: GRP_W]),
        .enable     (next_en_r[G3_LO +: GRP_W]),
        .trig_a     (g3_a),
        .trig_b     (g3_b),
        .nonoverlap (g3_nov_r),
        .direct     (g3_dir_r),
        .out_data   (out_data[G3_LO +: GRP_W]),
        .pin        (pin[G3_LO +: GRP_W])
    );

    // Group 2 drives outputs 11 to 8.
    ppu_group u_grp2 (
        .clk        (CLK),
        .rst_n      (RST_N),
        .wr_en      (wr_ok && ADDR == OFS_OUT_DATA),
        .wr_data    (WDATA[G2_LO +: GRP_W]),
        .next_data  (next_data_r[G2_LO +: GRP_W]),
        .enable     (next_en_r[G2_LO +: GRP_W]),
        .trig_a     (g2_a),
        .trig_b     (g2_b),
        .nonoverlap (g2_nov_r),
        .direct     (g2_dir_r),
        .out_data   (out_data[G2_LO +: GRP_W]),
        .pin        (pin[G2_LO +: GRP_W])
    );

    // Pins are ours only where pulse output is enabled and no other peripheral claims them.
    assign PULSE_OUT = pin;
    assign PULSE_OE  = next_en_r & ~OTHER_PERIPH_OE & {DATA_W{run}};

    // Checks on the unit, running and in module stop.
    sequence s_g3_norm_a;
        run && g3_a && !g3_nov_r;
    endsequence

    sequence s_g3_nov_b_only;
        run && g3_nov_r && g3_b && !g3_a;
    endsequence

    a_stop_freezes_data: assert property (@(posedge CLK) disable iff (!RST_N)
        MODULE_STOP |=> $stable(out_data))
        else $error("output data changed in module stop");

    a_stop_blocks_write: assert property (@(posedge CLK) disable iff (!RST_N)
        (MODULE_STOP && WR) |=> $stable(next_en_r) && $stable(next_data_r))
        else $error("register written in module stop");

    a_disabled_no_xfer: assert property (@(posedge CLK) disable iff (!RST_N)
        !(WR && ADDR == OFS_OUT_DATA) |=> ((out_data ^ $past(out_data)) & ~$past(next_en_r)) == 8'h00)
        else $error("disabled bit changed without a write");

    a_enabled_write_block: assert property (@(posedge CLK) disable iff (!RST_N)
        (WR && ADDR == OFS_OUT_DATA && !g3_a && !g3_b && !g2_a && !g2_b)
        |=> ((out_data ^ $past(out_data)) & $past(next_en_r)) == 8'h00)
        else $error("software write changed an enabled bit");

    a_norm_xfer_g3: assert property (@(posedge CLK) disable iff (!RST_N)
        s_g3_norm_a |=> (out_data[7:4] & $past(next_en_r[7:4])) == ($past(next_data_r[7:4]) & $past(next_en_r[7:4])))
        else $error("group 3 match A did not copy next data");

    a_nov_b_zero_only: assert property (@(posedge CLK) disable iff (!RST_N)
        s_g3_nov_b_only |=> (out_data[7:4] & $past(next_en_r[7:4]))
            == ($past(out_data[7:4]) & $past(next_data_r[7:4]) & $past(next_en_r[7:4])))
        else $error("group 3 match B copied a one or missed a zero");

    a_norm_ignores_b: assert property (@(posedge CLK) disable iff (!RST_N)
        (!g2_nov_r && g2_b && !g2_a && !(WR && ADDR == OFS_OUT_DATA)) |=> $stable(out_data[3:0]))
        else $error("group 2 updated on match B in normal mode");

    a_nov_a_all: assert property (@(posedge CLK) disable iff (!RST_N)
        (run && g2_nov_r && g2_a) |=> (out_data[3:0] & $past(next_en_r[3:0]))
            == ($past(next_data_r[3:0]) & $past(next_en_r[3:0])))
        else $error("group 2 match A in non-overlap did not copy all bits");

    a_capture_trigger: assert property (@(posedge CLK) disable iff (!RST_N)
        (REG_A_IS_CAPTURE[g2_sel_r] && run) |-> (g2_a == CAPTURE_A[g2_sel_r]))
        else $error("capture event not used as group 2 trigger");

    a_invert_pins: assert property (@(posedge CLK) disable iff (!RST_N)
        ($past(g3_dir_r) == g3_dir_r) |-> PULSE_OUT[7:4] == (g3_dir_r ? out_data[7:4] : ~out_data[7:4]))
        else $error("group 3 pin level does not follow inversion setting");

    a_rsvd_read_back: assert property (@(posedge CLK) disable iff (!RST_N)
        (RD && run && ADDR == OFS_OUT_MODE) |=> (RDATA & 8'h33) == 8'h30)
        else $error("reserved mode bits read wrong");

    a_pin_shared_off: assert property (@(posedge CLK) disable iff (!RST_N)
        (PULSE_OE & OTHER_PERIPH_OE) == 8'h00)
        else $error("pulse output enabled on a pin owned elsewhere");
endmodule // ppu_top

// [verification/ppu_timer_model.sv]
// Timer pulse unit model that raises match and capture events towards the pulse pattern unit.
`timescale 1ns/100ps
module ppu_timer_model (
    // Clock and reset.
    input  wire logic       clk,
    input  wire logic       rst_n,
    // Event request from the bench: kind 0 match A, 1 match B, 2 capture A.
    input  wire logic       go,
    input  wire logic [1:0] kind,
    input  wire logic [1:0] chan,
    input  wire logic [3:0] delay,
    input  wire logic [3:0] cap_mode,
    // Timer events towards the unit.
    output logic      [3:0] match_a,
    output logic      [3:0] match_b,
    output logic      [3:0] capture_a,
    output logic      [3:0] reg_a_is_capture,
    output logic            busy
);
    logic       pend_r;
    logic [3:0] cnt_r;
    logic [1:0] kind_r;
    logic [1:0] chan_r;

    // Waits the requested delay, then raises one event for exactly one clock.
    always_ff @(posedge clk) begin
        match_a   <= 4'h0;
        match_b   <= 4'h0;
        capture_a <= 4'h0;
        if (!rst_n) begin
            pend_r <= 1'h0;
        end else if (go) begin
            pend_r <= 1'h1;
            cnt_r  <= delay;
            kind_r <= kind;
            chan_r <= chan;
        end else if (pend_r && cnt_r != 4'h0) begin
            cnt_r <= cnt_r - 4'h1;
        end else if (pend_r) begin
            pend_r <= 1'h0;
            case (kind_r)
                2'h0:    match_a[chan_r]   <= 1'h1;
                2'h1:    match_b[chan_r]   <= 1'h1;
                default: capture_a[chan_r] <= 1'h1;
            endcase
        end
    end

    // Register A mode is a plain level chosen by the bench.
    assign reg_a_is_capture = cap_mode;
    assign busy             = pend_r | (|match_a) | (|match_b) | (|capture_a);
endmodule // ppu_timer_model

// [verification/ppu_top_tb_top.sv]
// Self-checking testbench of the pulse pattern unit top.
`timescale 1ns/100ps
module ppu_top_tb_top;
    import ppu_pkg::*;
    logic              clk, rst_n, wr, rd, stop, go, busy;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata, rdata, pout, poe, other_oe, exp_out, en, nd, d;
    logic [NUM_CH-1:0] ma, mb, ca, cap_cfg, cap_mode;
    logic [1:0]        kind, chan;
    logic [3:0]        delay;
    int                errors, total_checks;

    // Clock at 200 MHz.
    initial begin
        clk = 1'h0;
        forever #2.5 clk = ~clk;
    end

    ppu_top DUT (.CLK(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
        .MODULE_STOP(stop), .MATCH_A(ma), .MATCH_B(mb), .CAPTURE_A(ca), .REG_A_IS_CAPTURE(cap_cfg),
        .OTHER_PERIPH_OE(other_oe), .PULSE_OUT(pout), .PULSE_OE(poe));
    ppu_timer_model timer (.clk(clk), .rst_n(rst_n), .go(go), .kind(kind), .chan(chan), .delay(delay),
        .cap_mode(cap_mode), .match_a(ma), .match_b(mb), .capture_a(ca), .reg_a_is_capture(cap_cfg),
        .busy(busy));

    // Compares one value and counts the result.
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] want);
        total_checks++;
        if (seen !== want) begin
            errors++;
            $display("BAD %s expected %h seen %h", what, want, seen);
        end
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // One-cycle register write.
    task automatic wr_reg(input logic [2:0] a, input logic [7:0] v);
        @(posedge clk);
        addr  <= a;
        wdata <= v;
        wr    <= 1'h1;
        @(posedge clk);
        wr <= 1'h0;
    endtask

    // One-cycle register read; data stand in the following cycle only.
    task automatic rd_chk(input string what, input logic [2:0] a, input logic [7:0] want);
        @(posedge clk);
        addr <= a;
        rd   <= 1'h1;
        @(posedge clk);
        rd <= 1'h0;
        #1 chk(what, rdata, want);
    endtask

    // Asks the timer for one event and waits, bounded, until it has been delivered.
    task automatic fire(input logic [1:0] k, input logic [1:0] c, input logic [3:0] dl);
        @(posedge clk);
        go    <= 1'h1;
        kind  <= k;
        chan  <= c;
        delay <= dl;
        @(posedge clk);
        go <= 1'h0;
        for (int i = 0; i < 40; i++) begin
            @(posedge clk);
            #1;
            if (!busy) return;
        end
        errors++;
        report_and_stop();
    endtask

    // Fires an event, updates the expected output data for the bits in m, and checks state and pins.
    task automatic xfer(input logic [1:0] k, input logic [1:0] c, input logic [7:0] m, input logic [3:0] dl);
        fire(k, c, dl);
        if (k == 2'h1) exp_out = exp_out & ~(m & ~nd);
        else exp_out = (exp_out & ~m) | (nd & m);
        chk("pins", pout, exp_out);
        rd_chk("output_data", OFS_OUT_DATA, exp_out);
    endtask

    // Module stop holds the unit: writes dropped, reads zero, pins not driven.
    task automatic t_stop;
        wr_reg(OFS_NEXT_EN, 8'hFF);
        rd_chk("read in stop", OFS_OUT_MODE, 8'h00);
        chk("oe in stop", poe, 8'h00);
        @(posedge clk) stop <= 1'h0;
        rd_chk("enable after stop", OFS_NEXT_EN, 8'h00);
        $display("test stop done");
    endtask

    // Reset values, reserved bits and the unmapped offset.
    task automatic t_regs;
        rd_chk("trigger_select", OFS_TRIG_SEL, 8'hFF);
        rd_chk("output_mode", OFS_OUT_MODE, 8'hF0);
        rd_chk("unmapped", 3'h7, 8'h00);
        wr_reg(OFS_TRIG_SEL, 8'h0F);
        rd_chk("trigger_select fixed", OFS_TRIG_SEL, 8'h0F);
        wr_reg(OFS_OUT_MODE, 8'hFC);
        rd_chk("output_mode fixed", OFS_OUT_MODE, 8'hFC);
        wr_reg(OFS_OUT_MODE, 8'hF0);
        wr_reg(OFS_NEXT_DATA_G3, 8'h5F);
        wr_reg(OFS_NEXT_DATA_G2, 8'hF3);
        rd_chk("next_data g3 view", OFS_NEXT_DATA_G3, 8'h5F);
        rd_chk("next_data g2 view", OFS_NEXT_DATA_G2, 8'hF3);
        rd_chk("next_data", OFS_NEXT_DATA, 8'h53);
        $display("test regs done");
    endtask

    // Preloaded output data drive the pins; enabled bits refuse processor writes.
    task automatic t_preload;
        wr_reg(OFS_OUT_DATA, 8'hA5);
        rd_chk("preload", OFS_OUT_DATA, 8'hA5);
        chk("preload pins", pout, 8'hA5);
        en = 8'hFC;
        wr_reg(OFS_NEXT_EN, en);
        wr_reg(OFS_OUT_DATA, 8'h00);
        exp_out = 8'hA4;
        rd_chk("write to enabled bits", OFS_OUT_DATA, exp_out);
        chk("oe", poe, en);
        $display("test preload done");
    endtask

    // Every channel code of both groups; match B is ignored in normal mode.
    task automatic t_select;
        nd = 8'h96;
        for (int c = 0; c < 4; c++) begin
            wr_reg(OFS_TRIG_SEL, {2'(c), 2'(3 - c), 4'hF});
            nd = ~nd;
            wr_reg(OFS_NEXT_DATA, nd);
            xfer(2'h1, 2'(c), 8'h00, 4'h0);
            xfer(2'h1, 2'(3 - c), 8'h00, 4'h0);
            xfer(2'h0, 2'(c), en & 8'hF0, 4'(c));
            xfer(2'h0, 2'(3 - c), en & 8'h0F, 4'h0);
        end
        $display("test select done");
    endtask

    // Non-overlapping transfers: B copies zeros only, A copies all.
    task automatic t_nonoverlap;
        wr_reg(OFS_TRIG_SEL, 8'hFF);
        wr_reg(OFS_OUT_MODE, 8'hFC);
        en = 8'hFF;
        wr_reg(OFS_NEXT_EN, en);
        nd = 8'h95;
        wr_reg(OFS_NEXT_DATA, nd);
        xfer(2'h0, 2'h3, en, 4'h2);
        nd = 8'h65;
        wr_reg(OFS_NEXT_DATA, nd);
        xfer(2'h1, 2'h3, en, 4'h5);
        xfer(2'h0, 2'h3, en, 4'h0);
        wr_reg(OFS_OUT_MODE, 8'hF0);
        $display("test nonoverlap done");
    endtask

    // Inverted groups drive the complement of their output data.
    task automatic t_invert;
        wr_reg(OFS_OUT_MODE, 8'h70);
        repeat (2) @(posedge clk);
        #1 chk("g3 inverted", pout, {~exp_out[7:4], exp_out[3:0]});
        wr_reg(OFS_OUT_MODE, 8'hB0);
        repeat (2) @(posedge clk);
        #1 chk("g2 inverted", pout, {exp_out[7:4], ~exp_out[3:0]});
        wr_reg(OFS_OUT_MODE, 8'hF0);
        repeat (2) @(posedge clk);
        $display("test invert done");
    endtask

    // Capture on register A replaces match A as the trigger.
    task automatic t_capture;
        cap_mode <= 4'h4;
        wr_reg(OFS_TRIG_SEL, 8'hAF);
        nd = 8'h3C;
        wr_reg(OFS_NEXT_DATA, nd);
        xfer(2'h0, 2'h2, 8'h00, 4'h0);
        xfer(2'h2, 2'h2, en, 4'h3);
        cap_mode <= 4'h0;
        $display("test capture done");
    endtask

    // A pin owned by another peripheral is not driven, yet transfers continue.
    task automatic t_share;
        // Pins change owner while no trigger is pending.
        @(posedge clk) other_oe <= 8'h3C;
        nd = 8'hC3;
        wr_reg(OFS_NEXT_DATA, nd);
        #1 chk("oe shared", poe, en & ~8'h3C);
        xfer(2'h0, 2'h2, en, 4'h0);
        @(posedge clk) stop <= 1'h1;
        @(posedge clk) #1 chk("oe stop", poe, 8'h00);
        $display("test share done");
    endtask

    // Main sequence: time-zero values, reset for 16 cycles, then the scenarios.
    initial begin
        errors = 0;
        total_checks = 0;
        {rst_n, wr, rd, go, kind, chan, delay, cap_mode} = '0;
        {addr, wdata, other_oe} = '0;
        stop = 1'h1;
        repeat (16) @(posedge clk);
        rst_n <= 1'h1;
        t_stop();
        t_regs();
        t_preload();
        t_select();
        t_nonoverlap();
        t_invert();
        t_capture();
        t_share();
        report_and_stop();
    end
endmodule // ppu_top_tb_top
